//--- logic/ipcc_top.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "ipcc_map.svh"
module ipcc_top (
	// clocking
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// interrupt sources
	input wire logic [7:0] irq_status,
	input wire logic [7:0] irq_mask,
	output logic [7:0] status_flagged,
	output logic global_irq_summary,
	// request pin
	output ipcc_pkg::ipcc_pin_s irq_pin,
	// chain pins
	input wire logic chain_pin_a_in,
	output ipcc_pkg::ipcc_pin_s chain_pin_a,
	input wire logic chain_pin_b_in,
	// acknowledge
	input wire logic irq_acknowledge,
	output logic ack_accepted
);
	import ipcc_pkg::*;

	// ***************
	// registers
	// ***************
	ipcc_cfg_s cfg_q;
	ipcc_state_e state_q;
	logic [2:0] sync_w;
	logic pin_a_s, pin_b_s, ack_s;
	logic req_w, match_w;

	assign pin_a_s = sync_w[0];
	assign pin_b_s = sync_w[1];
	assign ack_s = sync_w[2];

	ipcc_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.din({irq_acknowledge, chain_pin_b_in, chain_pin_a_in}),
		.dout(sync_w)
	);

	function automatic logic [7:0] cfg_byte(input ipcc_cfg_s c);
		logic [7:0] b;
		b = 8'h00;
		b[`IPCC_BIT_VIS] = c.masked_visible;
		b[`IPCC_BIT_SLAVE_ADDR_HI] = c.slave_addr_hi;
		b[`IPCC_BIT_SLAVE_ADDR_LO] = c.slave_addr_lo;
		b[`IPCC_BIT_CASCADE_SELECT] = c.cascade_select;
		b[`IPCC_BIT_IC1] = c.irq_drive_polarity;
		b[`IPCC_BIT_IC0] = c.irq_drive_type;
		return b;
	endfunction

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_q <= '0;
		end else if (ce && reg_wr && reg_addr == `IPCC_CFG_ADDR) begin
			cfg_q.masked_visible <= reg_wdata[`IPCC_BIT_VIS];
			cfg_q.slave_addr_hi <= reg_wdata[`IPCC_BIT_SLAVE_ADDR_HI];
			cfg_q.slave_addr_lo <= reg_wdata[`IPCC_BIT_SLAVE_ADDR_LO];
			cfg_q.cascade_select <= reg_wdata[`IPCC_BIT_CASCADE_SELECT];
			cfg_q.irq_drive_polarity <= reg_wdata[`IPCC_BIT_IC1];
			cfg_q.irq_drive_type <= reg_wdata[`IPCC_BIT_IC0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			if (reg_rd && reg_addr == `IPCC_CFG_ADDR) begin
				reg_rdata <= cfg_byte(cfg_q) & `IPCC_CFG_WMASK;
			end else if (reg_rd && reg_addr == `IPCC_STAT_ADDR) begin
				reg_rdata <= {5'h00, ack_accepted, state_q};
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ***************
	// status gating
	// ***************
	assign req_w = |(irq_status & ~irq_mask);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status_flagged <= 8'h00;
			global_irq_summary <= 1'b0;
		end else if (ce) begin
			// masked bits flagged only when visible; never summarized
			status_flagged <= cfg_q.masked_visible ? irq_status : (irq_status & ~irq_mask);
			global_irq_summary <= req_w;
		end
	end

	a_flag_masked_hidden: assert property (@(posedge clk) disable iff (!resetn)
		$past(ce) && $past(resetn) && !$past(cfg_q.masked_visible)
		|-> (status_flagged & $past(irq_mask)) == 8'h00)
		else $error("masked status flagged while not visible");

	a_summary_unmasked: assert property (@(posedge clk) disable iff (!resetn)
		$past(ce) && $past(resetn)
		|-> global_irq_summary == |($past(irq_status) & ~$past(irq_mask)))
		else $error("summary does not follow unmasked status");

	// ***************
	// acknowledge
	// ***************
	// address pins only count in mode 0
	assign match_w = cfg_q.cascade_select ? pin_b_s :
		({pin_b_s, pin_a_s} == {cfg_q.slave_addr_hi, cfg_q.slave_addr_lo});

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= IPCC_IDLE;
			ack_accepted <= 1'b0;
		end else if (ce) begin
			ack_accepted <= 1'b0;
			unique case (state_q)
				IPCC_IDLE: begin
					if (req_w) begin
						state_q <= IPCC_PEND;
					end
				end
				IPCC_PEND: begin
					if (!req_w) begin
						state_q <= IPCC_IDLE;
					end else if (ack_s && match_w) begin
						ack_accepted <= 1'b1;
						state_q <= IPCC_ACK;
					end
				end
				IPCC_ACK: begin
					if (!ack_s) begin
						state_q <= req_w ? IPCC_PEND : IPCC_IDLE;
					end
				end
				default: begin
					state_q <= IPCC_IDLE;
				end
			endcase
		end
	end

	a_ack_accept_cond: assert property (@(posedge clk) disable iff (!resetn)
		$rose(ack_accepted)
		|-> $past(state_q) == IPCC_PEND && $past(req_w) && $past(ack_s) && $past(match_w))
		else $error("acknowledge accepted without request or match");

	a_ack_one_pulse: assert property (@(posedge clk) disable iff (!resetn)
		ack_accepted && ce
		|=> !ack_accepted)
		else $error("acknowledge accepted for more than one cycle");

	// ***************
	// pin drivers
	// ***************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_pin <= '0;
		end else if (ce) begin
			if (!cfg_q.irq_drive_type) begin
				irq_pin.out <= 1'b0;
				irq_pin.oe <= req_w;
			end else begin
				irq_pin.out <= cfg_q.irq_drive_polarity ? req_w : !req_w;
				irq_pin.oe <= 1'b1;
			end
		end
	end

	a_od_drive_off: assert property (@(posedge clk) disable iff (!resetn)
		$past(ce) && $past(resetn) && !$past(cfg_q.irq_drive_type)
		|-> !irq_pin.out && irq_pin.oe == $past(req_w))
		else $error("open drain request pin driven wrongly");

	a_pp_drive_level: assert property (@(posedge clk) disable iff (!resetn)
		$past(ce) && $past(resetn) && $past(cfg_q.irq_drive_type)
		|-> irq_pin.oe && irq_pin.out == ($past(cfg_q.irq_drive_polarity) == $past(req_w)))
		else $error("push pull request pin level wrong");

	always_ff @(posedge clk) begin
		if (!resetn) begin
			chain_pin_a <= '0;
		end else if (ce) begin
			chain_pin_a.oe <= cfg_q.cascade_select;
			// low while the request is active, else pass upstream
			chain_pin_a.out <= cfg_q.cascade_select && !req_w && pin_b_s;
		end
	end

	a_chain_pins_input: assert property (@(posedge clk) disable iff (!resetn)
		$past(ce) && $past(resetn) && !$past(cfg_q.cascade_select)
		|-> !chain_pin_a.oe && !chain_pin_a.out)
		else $error("chain pin driven in slave address mode");

	a_chain_block_low: assert property (@(posedge clk) disable iff (!resetn)
		$past(ce) && $past(resetn) && $past(cfg_q.cascade_select) && $past(req_w)
		|-> chain_pin_a.oe && !chain_pin_a.out)
		else $error("downstream enable not low while request active");

	a_chain_pass_up: assert property (@(posedge clk) disable iff (!resetn)
		$past(ce) && $past(resetn) && $past(cfg_q.cascade_select) && !$past(req_w)
		|-> chain_pin_a.oe && chain_pin_a.out == $past(pin_b_s))
		else $error("upstream enable not passed downstream");
endmodule

//--- pkg/ipcc_map.svh
`ifndef IPCC_MAP_SVH
`define IPCC_MAP_SVH
// register index of the port configuration register
`define IPCC_CFG_ADDR 8'h00
// read-only state register (own choice)
`define IPCC_STAT_ADDR 8'h01
`define IPCC_CFG_RESET 8'h00
// field positions
`define IPCC_BIT_VIS 7
`define IPCC_BIT_SLAVE_ADDR_HI 4
`define IPCC_BIT_SLAVE_ADDR_LO 3
`define IPCC_BIT_CASCADE_SELECT 2
`define IPCC_BIT_IC1 1
`define IPCC_BIT_IC0 0
// writable bits; bits 6 and 5 read zero
`define IPCC_CFG_WMASK 8'h9F
`endif

//--- pkg/ipcc_pkg.sv
package ipcc_pkg;
	typedef struct packed {
		logic masked_visible;
		logic slave_addr_hi;
		logic slave_addr_lo;
		logic cascade_select;
		logic irq_drive_polarity;
		logic irq_drive_type;
	} ipcc_cfg_s;
	typedef struct packed {
		logic out;
		logic oe;
	} ipcc_pin_s;
	typedef enum logic [1:0] {
		IPCC_IDLE = 2'b00,
		IPCC_PEND = 2'b01,
		IPCC_ACK = 2'b10
	} ipcc_state_e;
endpackage

//--- logic/ipcc_sync.sv
`timescale 1ns/1ps
module ipcc_sync (
	// clocking
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// level
	input wire logic [2:0] din,
	output logic [2:0] dout
);
	logic [2:0] meta_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_q <= 3'h0;
			dout <= 3'h0;
		end else if (ce) begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

//--- testbench/ipcc_host.sv
`timescale 1ns/1ps
module ipcc_host (
	// pins
	input wire logic clk,
	input wire logic [1:0] sel,
	input wire logic ack_req,
	input wire ipcc_pkg::ipcc_pin_s pin_a,
	output logic a_in,
	output logic b_in,
	output logic ack
);
	always_ff @(posedge clk) begin
		ack <= ack_req;
		b_in <= sel[1];
		a_in <= pin_a.oe ? pin_a.out : sel[0];
	end
endmodule

//--- testbench/interrupt_port_cascade_config_tb.sv
`timescale 1ns/1ps
module interrupt_port_cascade_config_tb;
	import ipcc_pkg::*;
	logic clk = 0, resetn = 0, wr = 0, rd = 0, req = 0, ce = 1;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, st = 8'h00, mk = 8'h00, flg;
	logic [1:0] sel = 2'h0;
	logic a_in, b_in, ack, summ, acc;
	ipcc_pin_s irq, pa;
	int fails = 0, n_tests = 0;
	always #5 clk = ~clk;
	ipcc_top dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq_status(st), .irq_mask(mk),
		.status_flagged(flg), .global_irq_summary(summ), .irq_pin(irq), .chain_pin_a_in(a_in),
		.chain_pin_a(pa), .chain_pin_b_in(b_in), .irq_acknowledge(ack), .ack_accepted(acc));
	ipcc_host host (.clk(clk), .sel(sel), .ack_req(req), .pin_a(pa), .a_in(a_in),
		.b_in(b_in), .ack(ack));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", rdata, e);
	endtask
	task automatic settle;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic ackc(input logic e);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		req <= 1'b1;
		repeat (8) begin
			@(negedge clk);
			seen |= acc;
		end
		@(posedge clk);
		req <= 1'b0;
		repeat (5) @(posedge clk);
		chk("ack_accepted", {7'h0, seen}, {7'h0, e});
	endtask
	initial begin
		#20000;
		fails++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rdc(8'h00, 8'h00);
		wrr(8'h00, 8'hFF);
		rdc(8'h00, 8'h9F);
		rdc(8'h05, 8'h00);
		// a write while the clock enable is low is lost
		@(posedge clk);
		ce <= 1'b0;
		wrr(8'h00, 8'h00);
		ce <= 1'b1;
		rdc(8'h00, 8'h9F);
		// each drive code, request off then on
		for (int i = 0; i < 4; i++) begin
			wrr(8'h00, 8'(i));
			st <= 8'h00;
			settle;
			chk("irq_pin idle", {6'h0, irq}, {6'h0, i[0] & ~i[1], i[0]});
			st <= 8'h01;
			settle;
			chk("irq_pin active", {6'h0, irq}, {6'h0, i[0] & i[1], 1'b1});
		end
		wrr(8'h00, 8'h80);
		st <= 8'h03;
		mk <= 8'h03;
		settle;
		chk("flagged", flg, 8'h03);
		chk("summary", {7'h0, summ}, 8'h00);
		chk("irq_pin", {6'h0, irq}, 8'h00);
		wrr(8'h00, 8'h00);
		settle;
		chk("flagged hidden", flg, 8'h00);
		wrr(8'h00, 8'h10);
		mk <= 8'h00;
		sel <= 2'b10;
		ackc(1'b1);
		chk("pin_a", {6'h0, pa}, 8'h00);
		rdc(8'h01, 8'h01);
		sel <= 2'b01;
		ackc(1'b0);
		st <= 8'h00;
		sel <= 2'b10;
		ackc(1'b0);
		wrr(8'h00, 8'h04);
		settle;
		chk("pin_a pass", {6'h0, pa}, 8'h03);
		st <= 8'h01;
		settle;
		chk("pin_a block", {6'h0, pa}, 8'h01);
		chk("summary on", {7'h0, summ}, 8'h01);
		ackc(1'b1);
		sel <= 2'b00;
		ackc(1'b0);
		tally_and_finish;
	end
endmodule
